// file: logic/mic_irq_ctrl.sv
`timescale 1ns/100ps
// How it works
// R1: every flag sets on its event whatever its mask or the global enable.
// R2: global enable at control bit 7 passes unmasked requests or blocks all.
// R3: global enable plus a flag with its mask set vectors at once.
// R4: control register holds one enable bit per core source.
// R5: reset clears the global enable.
// R6: return-from-irq sets the global enable again.
// R7: pin, port-change and timer flags sit in the control register.
// R8: peripheral flags and masks in their own registers, group enable in control.
// R9: on vectoring clear global enable, push return address, load vector 0004.
// R10: software clears flags before re-enabling, or it re-enters at once.
// R11: software polls the flags to find the source of the common vector.
// R12: pin or port events reach the vector in three or four cycles.
// R13: latency does not depend on the length of the current instruction.
// R14: eleven sources combine through flag, mask and global enable.
// R15: a wake from sleep leaves its cause flag set.
// R16: after a wake with enable set, next instruction runs, then the vector.
// R17: an acknowledge while software clears the enable is still serviced.
// R18: software loops clearing and re-testing the enable until it reads clear.
// R19: pin flag sets on rising edge if edge select set, else falling.
// R20: timer rollover from all ones to zero sets the timer flag.
// R21: any change on the four upper port pins sets the port flag, bit 0.
// R22: request is enable AND (enabled core flags OR group AND peripheral ones).
module mic_irq_ctrl #(
	parameter int PF1 = mic_pkg::PF1_W,
	parameter int PF2 = mic_pkg::PF2_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event sources
	input wire logic external_irq_pin,
	input wire logic [mic_pkg::PORT_W-1:0] port_upper_pins,
	input wire logic [7:0] timer_zero,
	input wire logic [PF1-1:0] periph_event_one,
	input wire logic [PF2-1:0] periph_event_two,
	// processor core
	input wire logic core_sleeping,
	input wire logic core_instr_done,
	input wire logic core_return_from_irq,
	output logic core_vector,
	output logic core_push_return,
	output logic [mic_pkg::PC_W-1:0] core_vector_addr,
	output logic core_wake
);
	// ================================================================
	// state
	logic [7:0] irq_control_reg_q;
	logic [PF1-1:0] periph_flag_reg_one_q;
	logic [PF2-1:0] periph_flag_reg_two_q;
	logic [PF1-1:0] periph_mask_reg_one_q;
	logic [PF2-1:0] periph_mask_reg_two_q;
	logic [7:0] option_q;
	logic [7:0] timer_prev_q;
	logic post_wake_q;
	logic sleep_prev_q;
	logic vector_q;
	logic wake_q;
	logic [31:0] rdata_q;
	logic slverr_q;

	logic ext_sync;
	logic ext_prev;
	logic [mic_pkg::PORT_W-1:0] port_sync;
	logic [mic_pkg::PORT_W-1:0] port_prev;

	// ================================================================
	// pin synchronisers
	mic_sync #(.W(1)) u_ext_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(external_irq_pin),
		.sync_q(ext_sync),
		.prev_q(ext_prev)
	);

	mic_sync #(.W(mic_pkg::PORT_W)) u_port_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(port_upper_pins),
		.sync_q(port_sync),
		.prev_q(port_prev)
	);

	// ================================================================
	// event detection
	logic ext_edge_select;
	logic ext_event;
	logic port_change_event;
	logic timer_zero_overflow_event;

	assign ext_edge_select = option_q[mic_pkg::BIT_EDGE_SELECT];
	assign ext_event = ext_edge_select ? (ext_sync & ~ext_prev) // R19
		: (~ext_sync & ext_prev);
	assign port_change_event = |(port_sync ^ port_prev); // R21
	assign timer_zero_overflow_event = (timer_prev_q == mic_pkg::TIMER_ALL_ONES)
		&& (timer_zero == mic_pkg::TIMER_ZERO); // R20

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_prev_q <= mic_pkg::TIMER_ZERO;
		end else begin
			timer_prev_q <= timer_zero;
		end
	end

	// ================================================================
	// apb decode
	logic wr_en;
	logic rd_setup;
	logic mapped;

	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	always_comb begin
		unique case (paddr)
			mic_pkg::OFS_IRQ_CONTROL,
			mic_pkg::OFS_PERIPH_FLAG_ONE,
			mic_pkg::OFS_PERIPH_FLAG_TWO,
			mic_pkg::OFS_PERIPH_MASK_ONE,
			mic_pkg::OFS_PERIPH_MASK_TWO,
			mic_pkg::OFS_OPTION,
			mic_pkg::OFS_CORE_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// zero wait states: read data is caught in the setup cycle
	assign pready = 1'b1;
	assign prdata = rdata_q;
	assign pslverr = slverr_q;

	// ================================================================
	// request combine
	logic [2:0] core_flags;
	logic [2:0] core_masks;
	logic periph_pending;
	logic enabled_pending;
	logic irq_req;

	assign core_flags = {irq_control_reg_q[mic_pkg::BIT_TIMER_FLAG],
		irq_control_reg_q[mic_pkg::BIT_EXT_FLAG],
		irq_control_reg_q[mic_pkg::BIT_PORT_FLAG]};
	assign core_masks = {irq_control_reg_q[mic_pkg::BIT_TIMER_EN], // R4
		irq_control_reg_q[mic_pkg::BIT_EXT_EN],
		irq_control_reg_q[mic_pkg::BIT_PORT_EN]};
	assign periph_pending = irq_control_reg_q[mic_pkg::BIT_PERIPH_EN] // R8
		& (|(periph_flag_reg_one_q & periph_mask_reg_one_q)
		| |(periph_flag_reg_two_q & periph_mask_reg_two_q)); // R14
	assign enabled_pending = |(core_flags & core_masks) | periph_pending;
	assign irq_req = irq_control_reg_q[mic_pkg::BIT_GLOBAL_EN] // R22 R2
		& enabled_pending;

	// vectoring waits out sleep, the instruction after a wake and the cycle of a vector only;
	// the length of the running instruction is never looked at;
	// the cycle in which sleep ends is refused too, or the vector would
	// beat the instruction that follows the sleep
	logic take;
	assign take = irq_req & ~vector_q & ~core_sleeping & ~sleep_prev_q
		& ~post_wake_q; // R3 R13 R16

	// ================================================================
	// control register: flags and enables
	logic [7:0] ctrl_d;
	always_comb begin
		ctrl_d = irq_control_reg_q;
		if (wr_en && paddr == mic_pkg::OFS_IRQ_CONTROL) begin
			ctrl_d = pwdata[7:0];
		end
		if (core_return_from_irq) begin
			ctrl_d[mic_pkg::BIT_GLOBAL_EN] = 1'b1; // R6 R17
		end
		if (take) begin
			ctrl_d[mic_pkg::BIT_GLOBAL_EN] = 1'b0; // R9
		end
		// events win over a clearing write in the same cycle
		ctrl_d[mic_pkg::BIT_TIMER_FLAG] = ctrl_d[mic_pkg::BIT_TIMER_FLAG]
			| timer_zero_overflow_event; // R1 R7
		ctrl_d[mic_pkg::BIT_EXT_FLAG] = ctrl_d[mic_pkg::BIT_EXT_FLAG]
			| ext_event; // R1 R7
		ctrl_d[mic_pkg::BIT_PORT_FLAG] = ctrl_d[mic_pkg::BIT_PORT_FLAG]
			| port_change_event; // R1 R7
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_control_reg_q <= mic_pkg::RST_IRQ_CONTROL; // R5
		end else begin
			irq_control_reg_q <= ctrl_d;
		end
	end

	// ================================================================
	// peripheral flags and masks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_flag_reg_one_q <= '0;
			periph_flag_reg_two_q <= '0;
		end else begin
			if (wr_en && paddr == mic_pkg::OFS_PERIPH_FLAG_ONE) begin
				periph_flag_reg_one_q <= pwdata[PF1-1:0]
					| periph_event_one; // R1 R8
			end else begin
				periph_flag_reg_one_q <= periph_flag_reg_one_q
					| periph_event_one; // R1
			end
			if (wr_en && paddr == mic_pkg::OFS_PERIPH_FLAG_TWO) begin
				periph_flag_reg_two_q <= pwdata[PF2-1:0]
					| periph_event_two; // R1 R8
			end else begin
				periph_flag_reg_two_q <= periph_flag_reg_two_q
					| periph_event_two; // R1
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_mask_reg_one_q <= '0;
			periph_mask_reg_two_q <= '0;
			option_q <= mic_pkg::RST_OPTION;
		end else if (wr_en) begin
			if (paddr == mic_pkg::OFS_PERIPH_MASK_ONE) begin
				periph_mask_reg_one_q <= pwdata[PF1-1:0]; // R8
			end
			if (paddr == mic_pkg::OFS_PERIPH_MASK_TWO) begin
				periph_mask_reg_two_q <= pwdata[PF2-1:0]; // R8
			end
			if (paddr == mic_pkg::OFS_OPTION) begin
				option_q <= pwdata[7:0];
			end
		end
	end

	// ================================================================
	// core handshake, sleep and wake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_q <= 1'b0;
			wake_q <= 1'b0;
			sleep_prev_q <= 1'b0;
			post_wake_q <= 1'b0;
		end else begin
			vector_q <= take; // R9 R12
			// wake needs only an enabled flag, not the global enable
			wake_q <= core_sleeping & enabled_pending; // R15
			sleep_prev_q <= core_sleeping;
			if (sleep_prev_q && !core_sleeping) begin
				post_wake_q <= 1'b1; // R16
			end else if (core_instr_done) begin
				post_wake_q <= 1'b0; // R16
			end
		end
	end

	assign core_vector = vector_q;
	assign core_push_return = vector_q; // R9
	assign core_wake = wake_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_vector_addr <= '0;
		end else if (take) begin
			core_vector_addr <= mic_pkg::VECTOR_ADDR; // R9
		end
	end

	// ================================================================
	// read data
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		unique case (paddr)
			mic_pkg::OFS_IRQ_CONTROL: rd_mux[7:0] = irq_control_reg_q;
			mic_pkg::OFS_PERIPH_FLAG_ONE: rd_mux[PF1-1:0] = periph_flag_reg_one_q;
			mic_pkg::OFS_PERIPH_FLAG_TWO: rd_mux[PF2-1:0] = periph_flag_reg_two_q;
			mic_pkg::OFS_PERIPH_MASK_ONE: rd_mux[PF1-1:0] = periph_mask_reg_one_q;
			mic_pkg::OFS_PERIPH_MASK_TWO: rd_mux[PF2-1:0] = periph_mask_reg_two_q;
			mic_pkg::OFS_OPTION: rd_mux[7:0] = option_q;
			mic_pkg::OFS_CORE_STATUS: rd_mux[2:0] = {post_wake_q, irq_req,
				enabled_pending};
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= '0;
			slverr_q <= 1'b0;
		end else if (rd_setup) begin
			rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			slverr_q <= ~mapped;
		end
	end

	// ================================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	flag_sets_always_a: assert property (ext_event // R1
		|=> irq_control_reg_q[mic_pkg::BIT_EXT_FLAG])
		else $error("pin flag not set after edge");
	blocked_when_off_a: assert property ( // R2
		!irq_control_reg_q[mic_pkg::BIT_GLOBAL_EN] |=> !vector_q)
		else $error("vector taken with global enable clear");
	vector_at_once_a: assert property (irq_req && !vector_q && !core_sleeping
		&& !sleep_prev_q && !post_wake_q |=> core_vector) // R3
		else $error("pending request not vectored");
	gie_clears_a: assert property (core_vector && !$past(core_return_from_irq)
		|-> !irq_control_reg_q[mic_pkg::BIT_GLOBAL_EN]) // R9
		else $error("global enable still set after vector");
	vector_addr_a: assert property (core_vector
		|-> core_vector_addr == mic_pkg::VECTOR_ADDR
		&& core_push_return) // R9
		else $error("wrong vector address or no push");
	return_sets_a: assert property (core_return_from_irq && !take // R6
		|=> irq_control_reg_q[mic_pkg::BIT_GLOBAL_EN])
		else $error("return did not set global enable");
	pin_latency_a: assert property ($rose(ext_sync) && ext_edge_select
		&& irq_control_reg_q[mic_pkg::BIT_EXT_EN]
		&& irq_control_reg_q[mic_pkg::BIT_GLOBAL_EN] && !core_sleeping
		&& !post_wake_q && !vector_q && !take
		&& !core_return_from_irq && !wr_en |-> ##[1:2] core_vector) // R12
		else $error("pin latency out of range");
	timer_roll_a: assert property ((timer_prev_q == 8'hff)
		&& (timer_zero == 8'h00)
		|=> irq_control_reg_q[mic_pkg::BIT_TIMER_FLAG]) // R20
		else $error("timer rollover missed");
	port_change_a: assert property (port_sync != port_prev
		|=> irq_control_reg_q[mic_pkg::BIT_PORT_FLAG]) // R21
		else $error("port change missed");
	wake_hold_a: assert property (post_wake_q |-> !core_vector) // R16
		else $error("vector before instruction after wake");
	wake_cause_a: assert property (core_wake |-> $past(enabled_pending)) // R15
		else $error("wake without a pending flag");

	vector_seen_c: cover property (core_vector);
	wake_then_vector_c: cover property (core_wake ##[1:20] core_vector);
	return_seen_c: cover property (core_return_from_irq ##1
		irq_control_reg_q[mic_pkg::BIT_GLOBAL_EN]);
endmodule : mic_irq_ctrl

// file: logic/mic_pkg.sv
// ====================================================================
// shared constants of the interrupt control block
package mic_pkg;
	// ================================================================
	// register byte offsets on the apb bus
	localparam logic [7:0] OFS_IRQ_CONTROL = 8'h00;
	localparam logic [7:0] OFS_PERIPH_FLAG_ONE = 8'h04;
	localparam logic [7:0] OFS_PERIPH_FLAG_TWO = 8'h08;
	localparam logic [7:0] OFS_PERIPH_MASK_ONE = 8'h0c;
	localparam logic [7:0] OFS_PERIPH_MASK_TWO = 8'h10;
	localparam logic [7:0] OFS_OPTION = 8'h14;
	localparam logic [7:0] OFS_CORE_STATUS = 8'h18;

	// ================================================================
	// irq_control_reg bit positions
	localparam int BIT_GLOBAL_EN = 7;
	localparam int BIT_PERIPH_EN = 6;
	localparam int BIT_TIMER_EN = 5;
	localparam int BIT_EXT_EN = 4;
	localparam int BIT_PORT_EN = 3;
	localparam int BIT_TIMER_FLAG = 2;
	localparam int BIT_EXT_FLAG = 1;
	localparam int BIT_PORT_FLAG = 0;

	// option register: edge select of the external pin
	localparam int BIT_EDGE_SELECT = 6;

	// ================================================================
	// widths and reset values
	localparam int PF1_W = 7;
	localparam int PF2_W = 1;
	localparam int PORT_W = 4;
	localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
	localparam logic [7:0] RST_OPTION = 8'hff;
	localparam logic [7:0] TIMER_ALL_ONES = 8'hff;
	localparam logic [7:0] TIMER_ZERO = 8'h00;

	// ================================================================
	// core side
	localparam int PC_W = 13;
	localparam logic [12:0] VECTOR_ADDR = 13'h0004;
endpackage : mic_pkg

// file: logic/mic_sync.sv
`timescale 1ns/100ps
// ====================================================================
// two-stage synchroniser with a third stage for edge detection
module mic_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// asynchronous input and synchronised views
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_q,
	output logic [W-1:0] prev_q
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
endmodule : mic_sync

// file: tb/mcu_interrupt_control_test.sv
`timescale 1ns/100ps
`define CHK(n, e, g) cmp(n, 32'(e), 32'(g))
// ====================================================================
// self-checking bench of the interrupt control block
module mcu_interrupt_control_test;
	localparam logic [7:0] AC = mic_pkg::OFS_IRQ_CONTROL;
	localparam logic [7:0] AF1 = mic_pkg::OFS_PERIPH_FLAG_ONE;
	localparam logic [7:0] AF2 = mic_pkg::OFS_PERIPH_FLAG_TWO;
	localparam logic [7:0] AM1 = mic_pkg::OFS_PERIPH_MASK_ONE;
	localparam logic [7:0] AM2 = mic_pkg::OFS_PERIPH_MASK_TWO;
	localparam logic [7:0] AO = mic_pkg::OFS_OPTION;
	localparam logic [31:0] GE = 32'h1 << mic_pkg::BIT_GLOBAL_EN;
	localparam logic [31:0] PE = 32'h1 << mic_pkg::BIT_PERIPH_EN;
	localparam logic [31:0] TE = 32'h1 << mic_pkg::BIT_TIMER_EN;
	localparam logic [31:0] XE = 32'h1 << mic_pkg::BIT_EXT_EN;
	localparam logic [31:0] TF = 32'h1 << mic_pkg::BIT_TIMER_FLAG;
	localparam logic [31:0] XF = 32'h1 << mic_pkg::BIT_EXT_FLAG;
	localparam logic [31:0] PF = 32'h1 << mic_pkg::BIT_PORT_FLAG;
	localparam logic [31:0] ES = 32'h1 << mic_pkg::BIT_EDGE_SELECT;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, tmr;
	logic [31:0] pwdata, prdata, rd;
	logic pin, vec, push, wake, slp, done, ret, long_instr, sleep_cmd, ret_cmd;
	logic [3:0] port;
	logic [6:0] pe1;
	logic [0:0] pe2;
	logic [12:0] vaddr;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	int vcount;
	mic_irq_ctrl dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .external_irq_pin(pin),
		.port_upper_pins(port), .timer_zero(tmr), .periph_event_one(pe1),
		.periph_event_two(pe2), .core_sleeping(slp), .core_instr_done(done),
		.core_return_from_irq(ret), .core_vector(vec),
		.core_push_return(push), .core_vector_addr(vaddr), .core_wake(wake)
	);
	mic_core_model core_u (
		.pclk(pclk), .presetn(presetn), .long_instr(long_instr),
		.sleep_cmd(sleep_cmd), .ret_cmd(ret_cmd), .core_vector(vec),
		.core_sleeping(slp), .core_instr_done(done),
		.core_return_from_irq(ret), .vec_count(vcount)
	);
	// ================================================================
	// clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	// ================================================================
	// tasks
	task automatic cmp(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	// entered just after a rising edge; leaves one idle cycle
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no fixed wait count: only the bench timeout ends a stuck access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wait_vec(output int k);
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (vec !== 1'b1 && k < 12);
	endtask : wait_vec
	task automatic ret_pulse();
		ret_cmd <= 1'b1;
		@(posedge pclk);
		ret_cmd <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : ret_pulse
	task automatic done_t(input string s);
		$display("test %s done", s);
	endtask : done_t
	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	// ================================================================
	// main sequence
	initial begin
		int v0, n, n0, ev2;
		logic [6:0] m, ev;
		logic pen;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pin = 1'b0;
		port = 4'h0;
		tmr = 8'h00;
		pe1 = 7'h00;
		pe2 = 1'b0;
		long_instr = 1'b0;
		sleep_cmd = 1'b0;
		ret_cmd = 1'b0;
		void'($urandom(65));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, AC, 0);
		`CHK("ctrl reset", mic_pkg::RST_IRQ_CONTROL, rd);
		apb(0, 8'h1c, 0);
		`CHK("unmapped err", 1, err);
		`CHK("unmapped data", 0, rd);
		done_t("reset");
		// events with every mask and the global enable clear
		tmr <= mic_pkg::TIMER_ALL_ONES;
		@(posedge pclk);
		tmr <= mic_pkg::TIMER_ZERO;
		port <= 4'h5;
		pin <= 1'b1;
		v0 = vcount;
		repeat (6) @(posedge pclk);
		apb(0, AC, 0);
		`CHK("masked flags", TF | XF | PF, rd);
		`CHK("masked no vector", v0, vcount);
		apb(1, AO, 0);
		apb(1, AC, 0);
		pin <= 1'b0;
		repeat (6) @(posedge pclk);
		apb(0, AC, 0);
		`CHK("falling edge", XF, rd);
		apb(1, AC, 0);
		pin <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(0, AC, 0);
		`CHK("rising ignored", 0, rd);
		apb(1, AO, ES);
		done_t("flags");
		// pin latency with short and long instructions
		for (int i = 0; i < 2; i++) begin
			long_instr <= i[0];
			pin <= 1'b0;
			apb(1, AC, GE | XE);
			v0 = vcount;
			pin <= 1'b1;
			wait_vec(n);
			`CHK("latency", 1, n > 3 && n < 6);
			if (i == 0)
				n0 = n;
			`CHK("latency same", n0, n);
			`CHK("push", 1, push);
			`CHK("vector addr", mic_pkg::VECTOR_ADDR, vaddr);
			apb(0, AC, 0);
			`CHK("gen cleared", XE | XF, rd);
		end
		ret_pulse();
		`CHK("re-entry", v0 + 2, vcount);
		apb(1, AC, XE);
		ret_pulse();
		apb(0, AC, 0);
		`CHK("gen restored", GE | XE, rd);
		`CHK("no re-entry", v0 + 2, vcount);
		// software disables globally and re-tests until it reads clear
		do begin
			apb(1, AC, XE);
			apb(0, AC, 0);
		end while ((rd & GE) != 0);
		`CHK("gen off", 0, rd & GE);
		done_t("vector");
		// peripheral sources, random masks and events
		apb(1, AM2, 32'h1);
		for (int i = 0; i < 8; i++) begin
			m = (i == 1) ? 7'h00 : 7'($urandom);
			ev = (i == 0) ? 7'h7f : 7'($urandom);
			ev2 = $urandom & 1;
			pen = (i < 2) | 1'($urandom);
			apb(1, AC, 0);
			apb(1, AF1, 0);
			apb(1, AF2, 0);
			apb(1, AM1, 32'(m));
			apb(1, AC, GE | (pen ? PE : 32'h0));
			v0 = vcount;
			pe1 <= ev;
			pe2 <= 1'(ev2);
			@(posedge pclk);
			pe1 <= 7'h00;
			pe2 <= 1'b0;
			repeat (4) @(posedge pclk);
			n = v0 + int'(pen && ((ev & m) != 0 || ev2 != 0));
			`CHK("periph vector", n, vcount);
			apb(0, AF1, 0);
			`CHK("periph flags one", ev, rd);
			apb(0, AF2, 0);
			`CHK("periph flags two", ev2, rd);
		end
		done_t("periph");
		// wake from sleep on a timer rollover
		apb(1, AC, GE | TE);
		sleep_cmd <= 1'b1;
		tmr <= mic_pkg::TIMER_ALL_ONES;
		v0 = vcount;
		repeat (2) @(posedge pclk);
		tmr <= mic_pkg::TIMER_ZERO;
		repeat (4) @(posedge pclk);
		`CHK("wake", 1, wake);
		`CHK("asleep no vector", v0, vcount);
		apb(0, AC, 0);
		`CHK("wake cause", GE | TE | TF, rd);
		apb(0, mic_pkg::OFS_CORE_STATUS, 0);
		`CHK("status asleep", 32'h3, rd);
		sleep_cmd <= 1'b0;
		// one instruction must run before the vector, so not at once
		wait_vec(n);
		`CHK("wake order", 1, n > 3 && n < 8);
		repeat (2) @(posedge pclk);
		`CHK("vector after wake", v0 + 1, vcount);
		done_t("sleep");
		close_out();
	end
endmodule : mcu_interrupt_control_test

// file: tb/mic_core_model.sv
`timescale 1ns/100ps
// ====================================================================
// core stand-in: paces instructions, sleeps, returns, counts vectors
module mic_core_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench commands
	input wire logic long_instr,
	input wire logic sleep_cmd,
	input wire logic ret_cmd,
	// block side
	input wire logic core_vector,
	output logic core_sleeping,
	output logic core_instr_done,
	output logic core_return_from_irq,
	output int vec_count
);
	logic phase_q;
	// two-cycle instructions end every other cycle; none end after the first cycle asleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= 1'b0;
			core_instr_done <= 1'b0;
			core_sleeping <= 1'b0;
			core_return_from_irq <= 1'b0;
			vec_count <= 0;
		end else begin
			phase_q <= long_instr && !phase_q;
			core_instr_done <= !core_sleeping && (!long_instr || phase_q);
			core_sleeping <= sleep_cmd;
			core_return_from_irq <= ret_cmd;
			vec_count <= vec_count + int'(core_vector);
		end
	end
endmodule : mic_core_model
